/* design/pfac_pkg.sv */
// Package for the program flash access controller.
// Holds register offsets, field positions, reset values and shared types.
package pfac_pkg;
   localparam int          PFAC_AW          = 12;
   localparam logic [11:0] OFF_CONTROL      = 12'h18C;
   localparam logic [11:0] OFF_UNLOCK       = 12'h18D;
   localparam logic [11:0] OFF_ADDR_LOW     = 12'h18E;
   localparam logic [11:0] OFF_ADDR_HIGH    = 12'h18F;
   localparam logic [11:0] OFF_DATA_LOW     = 12'h190;
   localparam logic [11:0] OFF_DATA_HIGH    = 12'h191;
   localparam logic [11:0] OFF_IRQ_STATUS   = 12'h1A0;
   localparam logic [11:0] OFF_IRQ_MASK     = 12'h1A1;
   localparam int          CTL_RD_BIT       = 0;
   localparam int          CTL_WR_BIT       = 1;
   localparam int          CTL_EN_BIT       = 2;
   localparam int          IRQ_RD_BIT       = 0;
   localparam int          IRQ_WR_BIT       = 1;
   localparam logic [7:0]  UNLOCK_FIRST     = 8'h55;
   localparam logic [7:0]  UNLOCK_SECOND    = 8'hAA;
   localparam logic [7:0]  RESET_BYTE       = 8'h00;
   localparam logic [7:0]  CTL_IMPL_MASK    = 8'h07;
   localparam logic [7:0]  ADH_IMPL_MASK    = 8'h03;
   localparam logic [7:0]  DTH_IMPL_MASK    = 8'h3F;
   localparam logic [7:0]  IRQ_IMPL_MASK    = 8'h03;
   localparam logic [31:0] WB_ZERO          = 32'h0000_0000;

   typedef enum logic [1:0] {UNL_IDLE, UNL_GOT55, UNL_ARMED} pfac_unl_t;
   typedef enum logic [1:0] {PF_IDLE, PF_READ, PF_WRITE} pfac_state_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [9:0]  addr;
      logic [13:0] wdata;
   } pfac_flash_req_t;
endpackage : pfac_pkg

/* design/pfac_top.sv */
// Program flash access controller: Wishbone slave registers and flash port.
// Assumes a flash array that answers a request with done, one or more cycles
// later, and a Wishbone master on the same clock.
`timescale 1ns/10ps
// Functional notes
// - Data-low byte, read and write, eight bits.
// - Address-low byte, read and write, eight bits.
// - Data-high keeps six bits, top two zero.
// - Address-high keeps two bits, rest zero.
// - Write trigger set-only, cleared when done.
// - Read trigger stays set until done, then hardware clears it.
// - Unlock register write-only, used for sequence.
module pfac_top
   import pfac_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   // Wishbone slave.
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [PFAC_AW-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // Flash array port.
   output pfac_flash_req_t       flash_o,
   input  wire logic [13:0]      flash_rdata,
   input  wire logic             flash_done,
   // Interrupt.
   output logic                  irq
);
   logic [7:0]       adl_q, adl_d, adh_q, adh_d, dtl_q, dtl_d, dth_q, dth_d;
   logic             en_q, en_d, ack_q, ack_d, irq_q, irq_d;
   logic [1:0]       sts_q, sts_d, msk_q, msk_d;
   logic [31:0]      rdat_q, rdat_d;
   pfac_unl_t        unl_q, unl_d;
   pfac_state_t      st_q, st_d;
   pfac_flash_req_t  frq_q, frq_d;
   logic             acc, wr_acc, wr_trig, rd_trig;
   logic [7:0]       wbyte;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      return a == o;
   endfunction : hit

   // Reads and writes build the flash word address the same way.
   function automatic logic [9:0] word_addr(input logic [7:0] hi,
                                            input logic [7:0] lo);
      return {hi[1:0], lo};
   endfunction : word_addr

   // Only a single new access is decoded; ack_q masks the held request.
   assign acc    = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_acc = acc && wb_we_i && wb_sel_i[0];
   assign wbyte  = wb_dat_i[7:0];
   assign rd_trig = wr_acc && hit(wb_adr_i, OFF_CONTROL)
                    && wbyte[CTL_RD_BIT] && st_q == PF_IDLE;
   assign wr_trig = wr_acc && hit(wb_adr_i, OFF_CONTROL) && !rd_trig
                    && wbyte[CTL_WR_BIT] && (en_q || wbyte[CTL_EN_BIT])
                    && unl_q == UNL_ARMED && st_q == PF_IDLE;

   always_comb begin
      adl_d  = adl_q;
      adh_d  = adh_q;
      dtl_d  = dtl_q;
      dth_d  = dth_q;
      en_d   = en_q;
      msk_d  = msk_q;
      sts_d  = sts_q;
      unl_d  = unl_q;
      st_d   = st_q;
      frq_d  = frq_q;
      ack_d  = acc;
      rdat_d = WB_ZERO;
      // Unmapped and write-only offsets fall through and read as zero.
      if (acc && !wb_we_i) begin
         if (hit(wb_adr_i, OFF_CONTROL))
            rdat_d[7:0] = {5'h00, en_q, st_q == PF_WRITE, st_q == PF_READ};
         else if (hit(wb_adr_i, OFF_ADDR_LOW))
            rdat_d[7:0] = adl_q;
         else if (hit(wb_adr_i, OFF_ADDR_HIGH))
            rdat_d[7:0] = adh_q & ADH_IMPL_MASK;
         else if (hit(wb_adr_i, OFF_DATA_LOW))
            rdat_d[7:0] = dtl_q;
         else if (hit(wb_adr_i, OFF_DATA_HIGH))
            rdat_d[7:0] = dth_q & DTH_IMPL_MASK;
         else if (hit(wb_adr_i, OFF_IRQ_STATUS))
            rdat_d[1:0] = sts_q;
         else if (hit(wb_adr_i, OFF_IRQ_MASK))
            rdat_d[1:0] = msk_q;
      end
      // Any access other than the two unlock writes breaks the sequence.
      if (acc) begin
         if (wr_acc && hit(wb_adr_i, OFF_UNLOCK)) begin
            if (wbyte == UNLOCK_FIRST)
               unl_d = UNL_GOT55;
            else if (wbyte == UNLOCK_SECOND && unl_q == UNL_GOT55)
               unl_d = UNL_ARMED;
            else
               unl_d = UNL_IDLE;
         end else begin
            unl_d = UNL_IDLE;
         end
      end
      if (wr_acc) begin
         if (hit(wb_adr_i, OFF_ADDR_LOW))
            adl_d = wbyte;
         if (hit(wb_adr_i, OFF_ADDR_HIGH))
            adh_d = wbyte & ADH_IMPL_MASK;
         if (hit(wb_adr_i, OFF_DATA_LOW) && st_q == PF_IDLE)
            dtl_d = wbyte;
         if (hit(wb_adr_i, OFF_DATA_HIGH) && st_q == PF_IDLE)
            dth_d = wbyte & DTH_IMPL_MASK;
         if (hit(wb_adr_i, OFF_CONTROL))
            en_d = wbyte[CTL_EN_BIT];
         if (hit(wb_adr_i, OFF_IRQ_MASK))
            msk_d = wbyte[1:0];
         if (hit(wb_adr_i, OFF_IRQ_STATUS))
            sts_d = sts_q & ~wbyte[1:0];
      end
      // One operation at a time: a trigger while busy is ignored, and a
      // read trigger wins over a write trigger set in the same byte.
      case (st_q)
         PF_IDLE: begin
            if (rd_trig) begin
               st_d  = PF_READ;
               frq_d = '{req: 1'b1, we: 1'b0,
                         addr: word_addr(adh_q, adl_q), wdata: 14'h0000};
            end else if (wr_trig) begin
               st_d  = PF_WRITE;
               frq_d = '{req: 1'b1, we: 1'b1,
                         addr: word_addr(adh_q, adl_q),
                         wdata: {dth_q[5:0], dtl_q}};
            end
         end
         PF_READ, PF_WRITE: begin
            // The request is a single pulse; address and word stay put.
            frq_d.req = 1'b0;
            if (flash_done) begin
               st_d = PF_IDLE;
               if (st_q == PF_READ) begin
                  dtl_d = flash_rdata[7:0];
                  dth_d = {2'b00, flash_rdata[13:8]};
                  sts_d[IRQ_RD_BIT] = 1'b1;
               end else begin
                  sts_d[IRQ_WR_BIT] = 1'b1;
               end
            end
         end
         default: st_d = PF_IDLE;
      endcase
      irq_d = |(sts_d & msk_d);
   end

   // Every output leaves from this bank, so none of them can glitch.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         adl_q  <= RESET_BYTE;
         adh_q  <= RESET_BYTE;
         dtl_q  <= RESET_BYTE;
         dth_q  <= RESET_BYTE;
         en_q   <= 1'b0;
         msk_q  <= 2'b00;
         sts_q  <= 2'b00;
         unl_q  <= UNL_IDLE;
         st_q   <= PF_IDLE;
         frq_q  <= '0;
         ack_q  <= 1'b0;
         rdat_q <= WB_ZERO;
         irq_q  <= 1'b0;
      end else if (clk_en) begin
         adl_q  <= adl_d;
         adh_q  <= adh_d;
         dtl_q  <= dtl_d;
         dth_q  <= dth_d;
         en_q   <= en_d;
         msk_q  <= msk_d;
         sts_q  <= sts_d;
         unl_q  <= unl_d;
         st_q   <= st_d;
         frq_q  <= frq_d;
         ack_q  <= ack_d;
         rdat_q <= rdat_d;
         irq_q  <= irq_d;
      end
   end

   assign wb_dat_o = rdat_q;
   assign wb_ack_o = ack_q;
   assign flash_o  = frq_q;
   assign irq      = irq_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b || !clk_en);

   a_adh_masked: assert property (adh_q[7:2] == 6'h00)
      else $error("address high upper bits set");
   a_dth_masked: assert property (dth_q[7:6] == 2'b00)
      else $error("data high upper bits set");
   // Flash operations: start, hold until done, capture.
   a_read_start: assert property (rd_trig
      |=> st_q == PF_READ && frq_q.req && !frq_q.we)
      else $error("read trigger did not start a read");
   a_write_gated: assert property (st_q == PF_IDLE
      && $past(st_q) == PF_IDLE
      |-> !(st_d == PF_WRITE && unl_q != UNL_ARMED))
      else $error("write started without unlock");
   a_write_done: assert property (st_q == PF_WRITE && flash_done
      |=> st_q == PF_IDLE && sts_q[IRQ_WR_BIT])
      else $error("write not completed on done");
   a_read_data: assert property (st_q == PF_READ && flash_done
      |=> {dth_q[5:0], dtl_q} == $past(flash_rdata))
      else $error("read data not captured");
   a_addr_form: assert property ($rose(frq_q.req)
      |-> frq_q.addr == {adh_q[1:0], adl_q})
      else $error("flash address wrong");
   a_enable_need: assert property (frq_q.req && frq_q.we
      |-> $past(en_q) || $past(wbyte[CTL_EN_BIT]))
      else $error("write without enable");
   a_write_hold: assert property (st_q == PF_WRITE && !flash_done
      |=> st_q == PF_WRITE)
      else $error("write ended before done");
   a_read_hold: assert property (st_q == PF_READ && !flash_done
      |=> st_q == PF_READ)
      else $error("read ended before done");
   a_busy_data: assert property (wr_acc && st_q == PF_WRITE
      && hit(wb_adr_i, OFF_DATA_LOW) |=> $stable(dtl_q))
      else $error("data low changed during a write");
   a_req_pulse: assert property (frq_q.req |=> !frq_q.req)
      else $error("flash request longer than one cycle");

   // Bus side: one answer per access, registers land as written.
   a_ack_pulse: assert property (ack_q |=> !ack_q)
      else $error("ack longer than one cycle");
   a_ack_next: assert property (acc |=> ack_q)
      else $error("bus access not answered next cycle");
   a_low_write: assert property (wr_acc && hit(wb_adr_i, OFF_ADDR_LOW)
      |=> adl_q == $past(wbyte))
      else $error("address low not written");
   a_adh_write: assert property (wr_acc && hit(wb_adr_i, OFF_ADDR_HIGH)
      |=> adh_q == ($past(wbyte) & ADH_IMPL_MASK))
      else $error("address high not written");
   a_data_low: assert property (wr_acc && hit(wb_adr_i, OFF_DATA_LOW)
      && st_q == PF_IDLE |=> dtl_q == $past(wbyte))
      else $error("data low not written");
   a_unlock_rd: assert property (acc && !wb_we_i
      && hit(wb_adr_i, OFF_UNLOCK) |=> wb_dat_o == WB_ZERO)
      else $error("unlock register readable");
   a_dth_read: assert property (acc && !wb_we_i
      && hit(wb_adr_i, OFF_DATA_HIGH) |=> wb_dat_o[7:6] == 2'b00)
      else $error("data high read shows upper bits");
   a_ctl_busy: assert property (acc && !wb_we_i && st_q == PF_WRITE
      && hit(wb_adr_i, OFF_CONTROL) |=> wb_dat_o[CTL_WR_BIT])
      else $error("write trigger not shown while busy");
   a_rdat_upper: assert property (wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits set");

   // The key sequence restarts on any access that is not the next key.
   a_first_key: assert property (wr_acc && hit(wb_adr_i, OFF_UNLOCK)
      && wbyte == UNLOCK_FIRST |=> unl_q == UNL_GOT55)
      else $error("first unlock key not recognised");
   a_unlock_arm: assert property (wr_acc && hit(wb_adr_i, OFF_UNLOCK)
      && wbyte == UNLOCK_SECOND && unl_q == UNL_GOT55
      |=> unl_q == UNL_ARMED)
      else $error("unlock pair not armed");
   a_seq_break: assert property (acc
      && !(wr_acc && hit(wb_adr_i, OFF_UNLOCK)) |=> unl_q == UNL_IDLE)
      else $error("unlock sequence survived another access");
   a_write_locked: assert property (wr_acc
      && hit(wb_adr_i, OFF_CONTROL) && unl_q != UNL_ARMED
      && st_q == PF_IDLE |=> st_q != PF_WRITE)
      else $error("locked write trigger accepted");
   a_enable_lock: assert property (wr_acc
      && hit(wb_adr_i, OFF_CONTROL) && !en_q && !wbyte[CTL_EN_BIT]
      && st_q == PF_IDLE |=> st_q != PF_WRITE)
      else $error("write trigger accepted while disabled");

   // Status bits are sticky; a done event in the clearing cycle wins.
   a_status_stick: assert property (sts_q[IRQ_RD_BIT]
      && !(wr_acc && hit(wb_adr_i, OFF_IRQ_STATUS) && wbyte[IRQ_RD_BIT])
      |=> sts_q[IRQ_RD_BIT])
      else $error("read status bit lost without clear");
   a_status_clear: assert property (wr_acc
      && hit(wb_adr_i, OFF_IRQ_STATUS) && wbyte[IRQ_WR_BIT]
      && !(st_q == PF_WRITE && flash_done) |=> !sts_q[IRQ_WR_BIT])
      else $error("write status bit not cleared");
   a_irq_level: assert property (irq_q == |(sts_q & msk_q))
      else $error("interrupt level disagrees with status");

   c_read: cover property (st_q == PF_READ ##1 st_q == PF_IDLE);
   c_write: cover property (st_q == PF_WRITE ##1 st_q == PF_IDLE);
   c_armed: cover property (unl_q == UNL_ARMED);
   c_irq: cover property ($rose(irq_q));
   c_locked: cover property (wr_acc && hit(wb_adr_i, OFF_CONTROL)
      && wbyte[CTL_WR_BIT] && unl_q != UNL_ARMED);
endmodule : pfac_top

/* dv/pfac_flash_model.sv */
// Behavioural program flash array for the access controller bench.
// Assumes a one-cycle request pulse and answers with a one-cycle done.
`timescale 1ns/10ps
module pfac_flash_model
   import pfac_pkg::*;
(
   // Clock and reset.
   input  wire logic            ref_clk,
   input  wire logic            rst_b,
   // Request side and pacing.
   input  wire pfac_flash_req_t flash_i,
   input  wire logic            slow,
   // Answer side.
   output logic      [13:0]     rdata,
   output logic                 done
);
   logic        busy_q;
   logic [3:0]  wait_q;
   logic [9:0]  last_addr;
   logic [13:0] last_wdata;
   int          wr_cnt;

   // Read data is only valid with done, so it toggles at all other times.
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q <= 1'h0;
         done   <= 1'h0;
         rdata  <= 14'h1555;
         wr_cnt <= 0;
      end else begin
         done  <= 1'h0;
         rdata <= ~rdata;
         if (flash_i.req) begin
            busy_q     <= 1'h1;
            wait_q     <= slow ? 4'h8 : 4'h0;
            last_addr  <= flash_i.addr;
            last_wdata <= flash_i.wdata;
            if (flash_i.we) begin
               wr_cnt <= wr_cnt + 1;
            end
         end else if (busy_q) begin
            if (wait_q == 4'h0) begin
               busy_q <= 1'h0;
               done   <= 1'h1;
               rdata  <= {flash_i.addr, 4'h9};
            end else begin
               wait_q <= wait_q - 4'h1;
            end
         end
      end
   end
endmodule : pfac_flash_model

/* dv/testbench.sv */
// Self-checking bench for the program flash access controller.
// Assumes the flash model above and a Wishbone answer within 20 cycles.
`timescale 1ns/10ps
module testbench
   import pfac_pkg::*;
();
   logic            ref_clk = 1'h0, rst_b = 1'h0, cyc = 1'h0, stb = 1'h0;
   logic            we = 1'h0, slow = 1'h0, ack, irq, fdone;
   logic            cken = 1'h1;
   logic [3:0]      sel = 4'h0;
   logic [11:0]     adr = 12'h000;
   logic [31:0]     dat = 32'h0, rdo;
   logic [13:0]     frd;
   pfac_flash_req_t fo;
   int              miscompares = 0, checks_done = 0, cycles = 0;

   pfac_top dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(cken),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
      .flash_o(fo), .flash_rdata(frd), .flash_done(fdone), .irq(irq));
   pfac_flash_model fm (.ref_clk(ref_clk), .rst_b(rst_b), .flash_i(fo),
      .slow(slow), .rdata(frd), .done(fdone));

   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         miscompares++;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // One classic cycle; read data is taken at the edge that samples ack.
   task automatic wb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; dat <= {24'h0, d};
      sel <= 4'h1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'h1 && n < 20);
      if (ack !== 1'h1) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, ack, 1'h1);
      end
      r = rdo;
      cyc <= 1'h0; stb <= 1'h0;
      sel <= 4'h0;
   endtask : wb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      wb(1'h1, a, d, r);
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] r;
      wb(1'h0, a, 8'h00, r);
      chk(r, {24'h0, e});
   endtask : rdchk

   task automatic idle(input logic [7:0] m);
      int n;
      logic [31:0] r;
      n = 0;
      do begin
         wb(1'h0, OFF_CONTROL, 8'h00, r);
         n++;
      end while ((r[7:0] & m) != 8'h00 && n < 20);
      chk({24'h0, r[7:0] & m}, 32'h0);
   endtask : idle

   task automatic t_regs();
      for (int i = 0; i < 6; i++) rdchk(OFF_CONTROL + 12'(i), RESET_BYTE);
      wr(OFF_ADDR_LOW, 8'hA5);
      rdchk(OFF_ADDR_LOW, 8'hA5);
      wr(OFF_ADDR_HIGH, 8'hFF);
      rdchk(OFF_ADDR_HIGH, 8'h03);
      wr(OFF_DATA_LOW, 8'hC3);
      rdchk(OFF_DATA_LOW, 8'hC3);
      wr(OFF_DATA_HIGH, 8'hFF);
      rdchk(OFF_DATA_HIGH, 8'h3F);
      wr(OFF_UNLOCK, 8'h55);
      rdchk(OFF_UNLOCK, 8'h00);
      rdchk(12'h1B0, 8'h00);
   endtask : t_regs

   // A low clock enable must hold off the bus answer until it rises again.
   task automatic t_freeze();
      cken <= 1'h0;
      fork
         begin
            repeat (4) @(posedge ref_clk);
            chk({31'h0, ack}, 32'h0);
            cken <= 1'h1;
         end
      join_none
      wr(OFF_DATA_LOW, 8'h3C);
      rdchk(OFF_DATA_LOW, 8'h3C);
   endtask : t_freeze

   // Read of word 0x3A5; the done status raises the interrupt only once unmasked.
   task automatic t_read(input logic s);
      slow <= s;
      wr(OFF_IRQ_MASK, 8'h00);
      wr(OFF_CONTROL, 8'h01);
      idle(8'h01);
      chk({22'h0, fm.last_addr}, 32'h3A5);
      rdchk(OFF_DATA_LOW, 8'h59);
      rdchk(OFF_DATA_HIGH, 8'h3A);
      rdchk(OFF_IRQ_STATUS, 8'h01);
      chk({31'h0, irq}, 32'h0);
      wr(OFF_IRQ_MASK, 8'h01);
      rdchk(OFF_IRQ_STATUS, 8'h01);
      chk({31'h0, irq}, 32'h1);
      wr(OFF_IRQ_STATUS, 8'h01);
      rdchk(OFF_IRQ_STATUS, 8'h00);
      chk({31'h0, irq}, 32'h0);
   endtask : t_read

   task automatic t_write();
      slow <= 1'h1;
      wr(OFF_DATA_LOW, 8'h34);
      wr(OFF_DATA_HIGH, 8'h12);
      wr(OFF_CONTROL, 8'h04);
      wr(OFF_UNLOCK, UNLOCK_FIRST);
      wr(OFF_UNLOCK, UNLOCK_SECOND);
      wr(OFF_CONTROL, 8'h06);
      rdchk(OFF_CONTROL, 8'h06);
      wr(OFF_DATA_LOW, 8'hEE);
      idle(8'h02);
      chk(32'(fm.wr_cnt), 32'h1);
      chk({18'h0, fm.last_wdata}, 32'h1234);
      rdchk(OFF_DATA_LOW, 8'h34);
      rdchk(OFF_IRQ_STATUS, 8'h02);
      chk({31'h0, irq}, 32'h0);
      wr(OFF_CONTROL, 8'h00);
      wr(OFF_UNLOCK, UNLOCK_FIRST);
      wr(OFF_UNLOCK, UNLOCK_SECOND);
      wr(OFF_CONTROL, 8'h02);
      rdchk(OFF_CONTROL, 8'h00);
      wr(OFF_UNLOCK, UNLOCK_FIRST);
      rdchk(OFF_CONTROL, 8'h00);
      wr(OFF_UNLOCK, UNLOCK_SECOND);
      wr(OFF_CONTROL, 8'h06);
      wr(OFF_UNLOCK, UNLOCK_SECOND);
      wr(OFF_UNLOCK, UNLOCK_FIRST);
      wr(OFF_CONTROL, 8'h06);
      rdchk(OFF_CONTROL, 8'h04);
      chk(32'(fm.wr_cnt), 32'h1);
   endtask : t_write

   initial begin
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'h1;
      t_regs();
      t_freeze();
      t_read(1'h0);
      t_read(1'h1);
      t_write();
      test_done();
   end
endmodule : testbench
